// *** brg_pkg.sv ***
// shared constants and carrier types for the bus region access guard
package brg_pkg;

    localparam int ADDR_W = 32;
    localparam int MST_W = 2;
    localparam int NMST = 4;
    localparam int CPU_CHANNELS = 16;
    localparam int DMA_CHANNELS = 8;
    localparam int MAX_CHANNELS = 16;
    localparam int CH_W = 4;
    localparam int CNT_W = 16;

    // address offset added to a refused access so it lands nowhere
    localparam logic [ADDR_W-1:0] REDIRECT_OFFSET = 32'h8000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

    // per-master protection mode of one region
    typedef enum logic [1:0] {
        BRG_OPEN    = 2'b00,
        BRG_RD_PROT = 2'b01,
        BRG_WR_PROT = 2'b10,
        BRG_LOCKED  = 2'b11
    } brg_mode_t;

    // one region channel: inclusive bounds, any width
    typedef struct packed {
        logic                       en;
        logic [ADDR_W-1:0]          lo;
        logic [ADDR_W-1:0]          hi;
        brg_mode_t [NMST-1:0]       mode;
    } brg_region_t;

    localparam brg_region_t REGION_RESET = '0;

    // one access presented by a bus master
    typedef struct packed {
        logic                       valid;
        logic                       write;
        logic [MST_W-1:0]           master;
        logic [ADDR_W-1:0]          addr;
    } brg_access_t;

    // record of the latest refused access
    typedef struct packed {
        logic                       write;
        logic [MST_W-1:0]           master;
        logic [ADDR_W-1:0]          addr;
    } brg_fault_t;

    localparam brg_fault_t FAULT_RESET = '0;

endpackage

// *** brg_chan.sv ***
// one region channel: address match and per-master rights check
`timescale 1ns/1ps
`default_nettype none
module brg_chan
    import brg_pkg::*;
(
    input  wire brg_region_t  cfg,
    input  wire brg_access_t  acc,
    output logic              hit,
    output logic              deny
);

    // true when the mode refuses this kind of access
    function automatic logic mode_blocks(input brg_mode_t m, input logic wr);
        mode_blocks = wr ? m[1] : m[0];
    endfunction

    // inclusive compare on both bounds, so widths need not be powers of two
    always_comb
    begin
        hit = cfg.en && acc.valid && (acc.addr >= cfg.lo) && (acc.addr <= cfg.hi);
        deny = hit && mode_blocks(cfg.mode[acc.master], acc.write);
    end

endmodule
`default_nettype wire

// *** brg_guard.sv ***
// region-based access guard placed between one bus master port and the interconnect
`timescale 1ns/1ps
`default_nettype none
module brg_guard
    import brg_pkg::*;
#(
    parameter bit DMA_PORT = 1'b0
)
(
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire logic                cfg_we,
    input  wire logic [CH_W-1:0]     cfg_sel,
    input  wire brg_region_t         cfg_wdata,
    input  wire logic [CH_W-1:0]     cfg_rsel,
    output logic                     cfg_err,
    output brg_region_t              cfg_rdata,
    input  wire brg_access_t         acc_in,
    output logic                     acc_in_ready,
    output brg_access_t              acc_out,
    input  wire logic                acc_out_ready,
    output logic                     acc_hit,
    output logic                     acc_fault,
    output brg_fault_t               fault_info,
    output logic                     fault_sticky,
    input  wire logic                fault_clr,
    output logic [CNT_W-1:0]         fault_count
);

    // channel count depends on which master the instance serves
    localparam int NCH = DMA_PORT ? DMA_CHANNELS : CPU_CHANNELS;

    // entries above the channel count stay at reset and read back as zero
    brg_region_t [MAX_CHANNELS-1:0] region_reg;
    brg_region_t [MAX_CHANNELS-1:0] region_next;
    logic        [MAX_CHANNELS-1:0] ch_hit;
    logic        [MAX_CHANNELS-1:0] ch_deny;
    logic                           refuse;
    logic                           taken;
    logic [ADDR_W-1:0]              redirect_addr;
    logic                           sel_ok;
    logic                           cfg_err_reg;
    logic                           cfg_err_next;
    brg_region_t                    cfg_rdata_reg;
    brg_region_t                    cfg_rdata_next;
    brg_fault_t                     fault_reg;
    brg_fault_t                     fault_next;
    logic                           sticky_reg;
    logic                           sticky_next;
    logic [CNT_W-1:0]               count_reg;
    logic [CNT_W-1:0]               count_next;

    // selector check used by both the write and the read-back path
    function automatic logic chan_valid(input logic [CH_W-1:0] sel);
        chan_valid = (32'(sel) < NCH);
    endfunction

    // every implemented channel checks the access in parallel
    genvar g;
    generate
        for (g = 0; g < MAX_CHANNELS; g++)
        begin : g_chan
            if (g < NCH)
            begin : g_live
                brg_chan u_chan (
                    .cfg  (region_reg[g]),
                    .acc  (acc_in),
                    .hit  (ch_hit[g]),
                    .deny (ch_deny[g])
                );
            end
            else
            begin : g_absent
                assign ch_hit[g] = 1'b0;
                assign ch_deny[g] = 1'b0;
            end
        end
    endgenerate

    // any refusing channel wins, so overlap never weakens protection
    assign refuse = |ch_deny;

    // a stalled beat is presented again, so it is only recorded once the target takes it
    assign taken = refuse && acc_out_ready;

    // the offset wraps at the top of the space; the redirected beat must land in unmapped space
    assign redirect_addr = acc_in.addr + REDIRECT_OFFSET;

    // access path is purely combinational: no latency for clean accesses
    always_comb
    begin
        acc_out = acc_in;
        if (refuse)
        begin
            acc_out.addr = redirect_addr;
        end
        // ready passes straight through, so the guard never adds a wait state
        acc_in_ready = acc_out_ready;
        acc_hit = |ch_hit;
        acc_fault = refuse;
    end

    // region table: writes to channels the instance lacks are refused
    always_comb
    begin
        sel_ok = chan_valid(cfg_sel);
        region_next = region_reg;
        cfg_err_next = 1'b0;
        if (cfg_we)
        begin
            if (sel_ok)
            begin
                region_next[cfg_sel] = cfg_wdata;
            end
            else
            begin
                // a refused write leaves the table untouched and only pulses the error flag
                cfg_err_next = 1'b1;
            end
        end
    end

    // table and error pulse registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            region_reg <= '0;
            cfg_err_reg <= 1'b0;
        end
        else
        begin
            region_reg <= region_next;
            cfg_err_reg <= cfg_err_next;
        end
    end

    // read-back port: one cycle behind the selector, zero for channels the instance lacks
    always_comb
    begin
        cfg_rdata_next = REGION_RESET;
        if (chan_valid(cfg_rsel))
        begin
            cfg_rdata_next = region_reg[cfg_rsel];
        end
    end

    // read-back register
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_rdata_reg <= REGION_RESET;
        end
        else
        begin
            cfg_rdata_reg <= cfg_rdata_next;
        end
    end

    // fault record: capture is only taken when the beat is accepted downstream
    always_comb
    begin
        fault_next = fault_reg;
        sticky_next = sticky_reg;
        count_next = count_reg;
        // clear first, so a set further down overrides it
        if (fault_clr)
        begin
            sticky_next = 1'b0;
        end
        if (taken)
        begin
            // set beats clear in the same cycle so no fault is lost
            sticky_next = 1'b1;
            fault_next.write = acc_in.write;
            fault_next.master = acc_in.master;
            fault_next.addr = acc_in.addr;
            // saturate rather than wrap, so a long fault storm still reads as many
            if (count_reg != CNT_MAX)
            begin
                count_next = count_reg + 16'h0001;
            end
        end
    end

    // fault record registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_reg <= FAULT_RESET;
            sticky_reg <= 1'b0;
            count_reg <= CNT_RESET;
        end
        else
        begin
            fault_reg <= fault_next;
            sticky_reg <= sticky_next;
            count_reg <= count_next;
        end
    end

    // registered outputs straight from their flops
    assign cfg_err = cfg_err_reg;
    assign cfg_rdata = cfg_rdata_reg;
    assign fault_info = fault_reg;
    assign fault_sticky = sticky_reg;
    assign fault_count = count_reg;

endmodule
`default_nettype wire

// *** brg_guard_properties.sv ***
// port checker for the bus region access guard
`timescale 1ns/1ps
`default_nettype none
module brg_chk
    import brg_pkg::*;
#(
    parameter bit DMA_PORT = 1'b0
)
(
    input wire logic             clk_sys,
    input wire logic             arst_n,
    input wire logic             cfg_we,
    input wire logic [CH_W-1:0]  cfg_sel,
    input wire logic             cfg_err,
    input wire brg_access_t      acc_in,
    input wire logic             acc_in_ready,
    input wire brg_access_t      acc_out,
    input wire logic             acc_out_ready,
    input wire logic             acc_hit,
    input wire logic             acc_fault,
    input wire brg_fault_t       fault_info,
    input wire logic             fault_sticky,
    input wire logic             fault_clr,
    input wire logic [CNT_W-1:0] fault_count
);
    localparam int LIM = DMA_PORT ? DMA_CHANNELS : CPU_CHANNELS;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // a refused access that the target took
    sequence taken_fault;
        acc_fault && acc_out_ready;
    endsequence
    a_pass_clean: assert property (!acc_fault |-> acc_out == acc_in)
        else $error("clean access altered");
    a_fault_offset: assert property (acc_fault |-> acc_hit && acc_in.valid && acc_out.addr == acc_in.addr + REDIRECT_OFFSET)
        else $error("refused access not redirected");
    a_ready_pass: assert property (acc_in_ready == acc_out_ready)
        else $error("ready not passed through");
    a_sticky_set: assert property (taken_fault |=> fault_sticky &&
        fault_info == {$past(acc_in.write), $past(acc_in.master), $past(acc_in.addr)})
        else $error("refusal not recorded");
    a_count_step: assert property (taken_fault ##0 fault_count != CNT_MAX |=>
        fault_count == $past(fault_count) + 16'h0001)
        else $error("fault count did not step");
    a_info_hold: assert property (!(acc_fault && acc_out_ready) |=> $stable(fault_info))
        else $error("fault record moved");
    a_hit_valid: assert property (acc_hit |-> acc_in.valid)
        else $error("hit without a valid access");
    a_count_hold: assert property (!(acc_fault && acc_out_ready) |=> $stable(fault_count))
        else $error("fault count moved");
    a_sticky_clr: assert property (fault_clr && !(acc_fault && acc_out_ready) |=> !fault_sticky)
        else $error("sticky not cleared");
    a_cfg_refuse: assert property (cfg_we && cfg_sel >= LIM |=> cfg_err)
        else $error("bad channel not flagged");
    a_cfg_ok: assert property (cfg_we && cfg_sel < LIM |=> !cfg_err)
        else $error("good channel flagged");
endmodule
bind brg_guard brg_chk #(.DMA_PORT(DMA_PORT)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_we(cfg_we),
    .cfg_sel(cfg_sel), .cfg_err(cfg_err), .acc_in(acc_in), .acc_in_ready(acc_in_ready), .acc_out(acc_out),
    .acc_out_ready(acc_out_ready), .acc_hit(acc_hit), .acc_fault(acc_fault), .fault_info(fault_info),
    .fault_sticky(fault_sticky), .fault_clr(fault_clr), .fault_count(fault_count));
`default_nettype wire

// *** brg_sink.sv ***
// downstream target model: ready at once, or one cycle in four when slow
`timescale 1ns/1ps
`default_nettype none
module brg_sink
(
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic slow,
    output logic      ready
);
    logic [1:0] cnt_reg;
    // stalls move just after the edge so the guard never sees a race
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            cnt_reg <= 2'h0;
        else
            cnt_reg <= #1 cnt_reg + 2'h1;
    end
    assign ready = !slow || cnt_reg == 2'h3;
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the region access guard, dma build
`timescale 1ns/1ps
`default_nettype none
module tb;
    import brg_pkg::*;
    logic             clk_sys = 1'b0;
    logic             arst_n = 1'b0;
    logic             cfg_we = 1'b0;
    logic [CH_W-1:0]  cfg_sel = 4'h0;
    brg_region_t      cfg_wdata = REGION_RESET;
    brg_access_t      acc_in = '0;
    logic             slow = 1'b0;
    logic             fault_clr = 1'b0;
    brg_access_t      acc_out;
    brg_region_t      cfg_rdata;
    logic             cfg_err, acc_out_ready, acc_fault, fault_sticky, dn, acc_hit;
    logic [CNT_W-1:0] fault_count;
    brg_region_t      rg [8];
    int               n_errors = 0;
    int               checks = 0;
    int               exp_cnt = 0;
    logic [31:0]      rnd = 32'h4B272FA8;
    localparam logic [31:0] EDGE [6] = '{32'h0FFF, 32'h1000, 32'h1806, 32'h1807, 32'h1FFF, 32'h2000};
    always #10 clk_sys = ~clk_sys;
    brg_guard #(.DMA_PORT(1'b1)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
        .cfg_wdata(cfg_wdata), .cfg_rsel(4'h7), .cfg_err(cfg_err), .cfg_rdata(cfg_rdata), .acc_in(acc_in),
        .acc_in_ready(), .acc_out(acc_out), .acc_out_ready(acc_out_ready), .acc_hit(acc_hit), .acc_fault(acc_fault),
        .fault_info(), .fault_sticky(fault_sticky), .fault_clr(fault_clr), .fault_count(fault_count));
    brg_sink u_sink (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow), .ready(acc_out_ready));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // any enabled channel whose mode for this master blocks the access type refuses it
    function automatic logic deny_f(input brg_access_t a);
        logic [1:0] m;
        deny_f = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            m = rg[i].mode[a.master];
            if (a.valid && rg[i].en && a.addr >= rg[i].lo && a.addr <= rg[i].hi && (a.write ? m[1] : m[0]))
                deny_f = 1'b1;
        end
    endfunction
    // any enabled channel that holds the address reports a hit, whatever its mode
    function automatic logic hit_f(input brg_access_t a);
        hit_f = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (a.valid && rg[i].en && a.addr >= rg[i].lo && a.addr <= rg[i].hi)
                hit_f = 1'b1;
        end
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cfg(input int s, input brg_region_t r);
        @(posedge clk_sys);
        #1 cfg_we = 1'b1;
        cfg_sel = s[3:0];
        cfg_wdata = r;
        if (s < 8)
            rg[s] = r;
        @(posedge clk_sys);
        #1 cfg_we = 1'b0;
        chk(cfg_err, s >= 8);
    endtask
    // main sequence: channels, then edge and random accesses, with stalls from beat 256 on
    initial
    begin
        for (int i = 0; i < 8; i++)
            rg[i] = REGION_RESET;
        repeat (20) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        chk(fault_count, CNT_RESET);
        cfg(0, {1'b1, 32'h1000, 32'h1FFF, 8'hE4});
        cfg(7, {1'b1, 32'h1800, 32'h1806, 8'h03});
        cfg(3, {1'b0, 32'h2000, 32'h27FF, 8'hFF});
        cfg(8, {1'b1, 32'h0, 32'hFFFFFFFF, 8'hFF});
        @(posedge clk_sys);
        #1 chk(cfg_rdata.hi, 32'h1806);
        chk(cfg_rdata.lo, rg[7].lo);
        chk({cfg_rdata.en, cfg_rdata.mode}, {rg[7].en, rg[7].mode});
        for (int i = 0; i < 400; i++)
        begin
            rnd = lfsr(rnd);
            @(posedge clk_sys);
            #1 slow = i[8];
            acc_in = {rnd[0] | (i < 6), rnd[1], (i < 6) ? 2'(i) ^ 2'h2 : rnd[3:2],
                      (i < 6) ? EDGE[i] : 32'h0F00 + rnd[31:8] % 32'h1A00};
            #8 dn = deny_f(acc_in);
            chk(acc_fault, dn);
            chk(acc_out.addr, acc_in.addr + (dn ? REDIRECT_OFFSET : 32'h0));
            chk(acc_out[35:32], acc_in[35:32]);
            chk(acc_hit, hit_f(acc_in));
            if (dn && acc_out_ready)
                exp_cnt++;
        end
        @(posedge clk_sys);
        #1 acc_in = '0;
        fault_clr = 1'b1;
        #8 chk(fault_count, exp_cnt);
        chk(fault_sticky, exp_cnt != 0);
        @(posedge clk_sys);
        #1 fault_clr = 1'b0;
        chk(fault_sticky, 1'b0);
        // mid-run reset with a locked access waiting: table and record must come back empty
        @(posedge clk_sys);
        #1 arst_n = 1'b0;
        acc_in = {1'b1, 1'b1, 2'h3, 32'h1000};
        @(posedge clk_sys);
        #1 arst_n = 1'b1;
        #8 chk(acc_fault, 1'b0);
        chk(fault_count, CNT_RESET);
        close_out;
    end
    // watchdog: the run needs under 500 cycles
    initial
    begin
        #40000;
        n_errors++;
        close_out;
    end
endmodule
`default_nettype wire
